// *** pkg/gpb_map.vh ***
// register map, field masks and reset values of the general-purpose port bank
`ifndef GPB_MAP_VH
`define GPB_MAP_VH

// number of ports and pins per port
`define GPB_NPORT 5
`define GPB_PINS 8

// address split: port select in [7:5], register select in [4:2]
`define GPB_PORT_LSB 5
`define GPB_REG_LSB 2
`define GPB_PORT_STRIDE 8'h20

// register offsets inside one port window
`define GPB_REG_OUT 3'h0
`define GPB_REG_DIR 3'h1
`define GPB_REG_OD 3'h2
`define GPB_REG_PU 3'h3
`define GPB_REG_PIN 3'h4
`define GPB_REG_ISTAT 3'h5
`define GPB_REG_ICLR 3'h6
`define GPB_REG_IEN 3'h7

// byte offsets of the same registers, port 0
`define GPB_OFF_OUT 8'h00
`define GPB_OFF_DIR 8'h04
`define GPB_OFF_OD 8'h08
`define GPB_OFF_PU 8'h0c
`define GPB_OFF_PIN 8'h10
`define GPB_OFF_ISTAT 8'h14
`define GPB_OFF_ICLR 8'h18
`define GPB_OFF_IEN 8'h1c

// reset values of all writable registers
`define GPB_OUT_RST 8'h00
`define GPB_DIR_RST 8'h00
`define GPB_OD_RST 8'h00
`define GPB_PU_RST 8'h00
`define GPB_IEN_RST 8'h00

// pin masks: implemented pins, output-only pins
`define GPB_ALL_MASK 8'hff
`define GPB_P3_IMPL_MASK 8'hdf
`define GPB_P1_OUTONLY_MASK 8'h20
`define GPB_NONE_MASK 8'h00

// ports with interrupt capability
`define GPB_IRQ_PORTS 5'h13

`endif

// *** hdl/gpb_bank.v ***
// five-port general-purpose pin bank with apb registers and one interrupt line
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "gpb_map.vh"

// register window of each port, base address = port number times 0x20:
//   +00 output value, +04 direction (1 = drive), +08 open-drain select,
//   +0c pull-up enable, +10 pin level (read only), +14 change status (sticky),
//   +18 status clear (write one), +1c interrupt enable
// an event is any level change of an input pin on ports 0, 1 and 4
// every transfer carries one wait state; irq_o follows a pin change by three edges
// limitation: pins are taken as already synchronous, there is no metastability filter
module gpb_bank
(
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // interrupt
  output wire irq_o,
  // port 0 pins
  input wire [7:0] port0_pins_i,
  output wire [7:0] port0_pins_o,
  output wire [7:0] port0_pins_oe_o,
  output wire [7:0] port0_pullup_o,
  // port 1 pins, bit 5 output only
  input wire [7:0] port1_pins_i,
  output wire [7:0] port1_pins_o,
  output wire [7:0] port1_pins_oe_o,
  output wire [7:0] port1_pullup_o,
  // port 2 pins
  input wire [7:0] port2_pins_i,
  output wire [7:0] port2_pins_o,
  output wire [7:0] port2_pins_oe_o,
  output wire [7:0] port2_pullup_o,
  // port 3 pins, bit 5 absent
  input wire [7:0] port3_pins_i,
  output wire [7:0] port3_pins_o,
  output wire [7:0] port3_pins_oe_o,
  output wire [7:0] port3_pullup_o,
  // port 4 pins
  input wire [7:0] port4_pins_i,
  output wire [7:0] port4_pins_o,
  output wire [7:0] port4_pins_oe_o,
  output wire [7:0] port4_pullup_o
);

  // implemented pins of a port
  function [7:0] impl_mask;
    input integer p;
    begin
      impl_mask = (p == 3) ? `GPB_P3_IMPL_MASK : `GPB_ALL_MASK;
    end
  endfunction

  // pins forced to output
  function [7:0] outonly_mask;
    input integer p;
    begin
      outonly_mask = (p == 1) ? `GPB_P1_OUTONLY_MASK : `GPB_NONE_MASK;
    end
  endfunction

  // write strobe of one register of the addressed port
  function reg_hit;
    input wr;
    input [2:0] idx;
    input [2:0] which;
    begin
      reg_hit = wr && (idx == which);
    end
  endfunction

  // apb state
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg irq_r;
  // input history is only trusted two edges after reset
  reg [1:0] arm_r;
  reg [7:0] rd_sel;

  // decoded fields of the current transfer
  wire [2:0] port_idx;
  wire [2:0] reg_idx;
  wire mapped;
  wire access;
  wire wr_go;
  // per-port buses, port n in bits [8n+7:8n]
  wire [39:0] pins_in_w;
  wire [39:0] pins_out_w;
  wire [39:0] pins_oe_w;
  wire [39:0] pullup_w;
  wire [39:0] rd_all_w;
  wire [4:0] irq_p_w;
  wire evt_ok;

  assign port_idx = paddr_i[7:5];
  assign reg_idx = paddr_i[4:2];
  // only ports 0 to 4 exist and every register is one aligned word
  assign mapped = (port_idx < 3'h5) && (paddr_i[1:0] == 2'h0);
  // first access cycle raises pready; the write lands on the edge that samples it
  assign access = psel_i && penable_i;
  assign wr_go = access && pready_r && pwrite_i && mapped;

  // all pin inputs as one bus, port 0 in the low byte
  assign pins_in_w = {port4_pins_i, port3_pins_i, port2_pins_i, port1_pins_i, port0_pins_i};

  // read mux over the five ports; unmapped ports select zero, never a bit past the bus
  always @*
  begin
    case (port_idx)
      3'h0: rd_sel = rd_all_w[7:0];
      3'h1: rd_sel = rd_all_w[15:8];
      3'h2: rd_sel = rd_all_w[23:16];
      3'h3: rd_sel = rd_all_w[31:24];
      3'h4: rd_sel = rd_all_w[39:32];
      default: rd_sel = 8'h00;
    endcase
  end

  // the first samples after reset have no valid predecessor, so a high pin would
  // look like a change; events wait until both history stages hold real levels
  always @(posedge clock_i)
  begin
    if (rst_i)
      arm_r <= 2'h0;
    else
      arm_r <= {arm_r[0], 1'b1};
  end
  assign evt_ok = arm_r[1];

  // one wait state so read data comes from a flop
  always @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else if (access && !pready_r)
    begin
      // unmapped addresses answer with an error and read as zero
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
      prdata_r <= (mapped && !pwrite_i) ? {24'h000000, rd_sel} : 32'h00000000;
    end
    else
    begin
      // ready and error are single-cycle pulses
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // per-port registers and pad drivers
  genvar p;
  generate
    for (p = 0; p < 5; p = p + 1)
    begin : g_port
      localparam [7:0] IMPL = impl_mask(p);
      localparam [7:0] FOUT = outonly_mask(p);
      localparam HASIRQ = (p == 0) || (p == 1) || (p == 4);
      // configuration, status and the two samples of the pins
      reg [7:0] out_r;
      reg [7:0] dir_r;
      reg [7:0] od_r;
      reg [7:0] pu_r;
      reg [7:0] ien_r;
      reg [7:0] ist_r;
      reg [7:0] pin_r;
      reg [7:0] pin_prev_r;
      // pad drivers, registered so outputs come from flops
      reg [7:0] pad_o_r;
      reg [7:0] pad_oe_r;
      reg [7:0] pad_pu_r;
      reg [7:0] rd_p;
      // decode and next-state nets
      wire wr_p;
      wire [7:0] wd;
      wire [7:0] evt;
      wire [7:0] clr;
      wire [7:0] dir_eff;
      wire [7:0] od_eff;
      wire [7:0] out_nxt;
      wire [7:0] od_nxt;
      wire [7:0] dir_nxt;
      wire [7:0] pu_nxt;
      wire [7:0] oe_nxt;
      wire we_out;
      wire we_dir;
      wire we_od;
      wire we_pu;
      wire we_clr;
      wire we_ien;

      assign wr_p = wr_go && (port_idx == p);
      // one strobe per register, decoded once here
      assign we_out = reg_hit(wr_p, reg_idx, `GPB_REG_OUT);
      assign we_dir = reg_hit(wr_p, reg_idx, `GPB_REG_DIR);
      assign we_od = reg_hit(wr_p, reg_idx, `GPB_REG_OD);
      assign we_pu = reg_hit(wr_p, reg_idx, `GPB_REG_PU);
      assign we_clr = reg_hit(wr_p, reg_idx, `GPB_REG_ICLR);
      // ports without interrupt logic never latch an enable
      assign we_ien = reg_hit(wr_p, reg_idx, `GPB_REG_IEN) && HASIRQ;
      // absent bit never stores anything
      assign wd = pwdata_i[7:0] & IMPL;
      // on ports 0, 1 and 4, any level change on an implemented input pin is an event, once history is valid
      assign evt = (HASIRQ && evt_ok) ? ((pin_r ^ pin_prev_r) & IMPL & ~FOUT) : 8'h00;
      assign clr = we_clr ? wd : 8'h00;
      // next register values, so pads follow a write on the same edge
      assign out_nxt = we_out ? wd : out_r;
      assign dir_nxt = we_dir ? wd : dir_r;
      assign od_nxt = we_od ? wd : od_r;
      assign pu_nxt = we_pu ? wd : pu_r;
      // output-only bit always drives, push-pull
      assign dir_eff = (dir_nxt | FOUT) & IMPL;
      assign od_eff = od_nxt & ~FOUT;
      // per bit: push-pull drives both levels, open-drain only while pulling low
      assign oe_nxt = dir_eff & (~od_eff | ~out_nxt);

      // register writes, input sampling and sticky status
      always @(posedge clock_i)
      begin
        if (rst_i)
        begin
          out_r <= `GPB_OUT_RST;
          dir_r <= `GPB_DIR_RST;
          od_r <= `GPB_OD_RST;
          pu_r <= `GPB_PU_RST;
          ien_r <= `GPB_IEN_RST;
          ist_r <= 8'h00;
          pin_r <= 8'h00;
          pin_prev_r <= 8'h00;
          pad_o_r <= 8'h00;
          // the output-only bit drives low already while reset is held
          pad_oe_r <= FOUT & IMPL;
          pad_pu_r <= 8'h00;
        end
        else
        begin
          pin_r <= pins_in_w[p*8 +: 8] & IMPL;
          pin_prev_r <= pin_r;
          out_r <= out_nxt;
          dir_r <= dir_nxt;
          od_r <= od_nxt;
          pu_r <= pu_nxt;
          if (we_ien)
            ien_r <= wd;
          // a new event wins over a clear in the same cycle
          ist_r <= (ist_r & ~clr) | evt;
          // open-drain only pulls low, so its data bit is held at zero
          pad_o_r <= out_nxt & ~od_eff & IMPL;
          pad_oe_r <= oe_nxt;
          // pull-up applies whatever the direction; never on the output-only bit
          pad_pu_r <= pu_nxt & IMPL & ~FOUT;
        end
      end

      // readback of this port; an absent bit is masked below, so every
      // register shows it as zero
      always @*
      begin
        case (reg_idx)
          `GPB_REG_OUT: rd_p = out_r;
          `GPB_REG_DIR: rd_p = dir_r | FOUT;
          `GPB_REG_OD: rd_p = od_r & ~FOUT;
          `GPB_REG_PU: rd_p = pu_r;
          `GPB_REG_PIN: rd_p = (pin_r & ~FOUT) | (out_r & FOUT);
          `GPB_REG_ISTAT: rd_p = ist_r;
          `GPB_REG_IEN: rd_p = ien_r;
          default: rd_p = 8'h00; // clear register is write-only
        endcase
      end

      // gather this port into the shared buses
      assign rd_all_w[p*8 +: 8] = rd_p & IMPL;
      assign irq_p_w[p] = |(ist_r & ien_r);
      assign pins_out_w[p*8 +: 8] = pad_o_r;
      assign pins_oe_w[p*8 +: 8] = pad_oe_r;
      assign pullup_w[p*8 +: 8] = pad_pu_r;
    end
  endgenerate

  // level interrupt, registered so it never glitches
  // one cycle of latency is traded for a clean pin
  always @(posedge clock_i)
  begin
    if (rst_i)
      irq_r <= 1'b0;
    else
      irq_r <= |irq_p_w;
  end

  // outputs straight from flops
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o = irq_r;

  // port 0 pads
  assign port0_pins_o = pins_out_w[7:0];
  assign port0_pins_oe_o = pins_oe_w[7:0];
  assign port0_pullup_o = pullup_w[7:0];

  // port 1 pads
  assign port1_pins_o = pins_out_w[15:8];
  assign port1_pins_oe_o = pins_oe_w[15:8];
  assign port1_pullup_o = pullup_w[15:8];

  // port 2 pads
  assign port2_pins_o = pins_out_w[23:16];
  assign port2_pins_oe_o = pins_oe_w[23:16];
  assign port2_pullup_o = pullup_w[23:16];

  // port 3 pads, bit 5 held at zero
  assign port3_pins_o = pins_out_w[31:24];
  assign port3_pins_oe_o = pins_oe_w[31:24];
  assign port3_pullup_o = pullup_w[31:24];

  // port 4 pads
  assign port4_pins_o = pins_out_w[39:32];
  assign port4_pins_oe_o = pins_oe_w[39:32];
  assign port4_pullup_o = pullup_w[39:32];

endmodule // gpb_bank

// *** verif/gpb_board.sv ***
// board-side pads of the port bank
`timescale 1ns/10ps
module gpb_board
(
  // clock for the floating pattern
  input wire clock_i,
  // module side of the pad
  input wire [7:0] oe_i,
  input wire [7:0] o_i,
  input wire [7:0] pu_i,
  // external driver
  input wire [7:0] drv_i,
  input wire [7:0] ext_i,
  // resolved pad level
  output wire [7:0] lvl_o
);
  logic [7:0] flt_r = 8'h00;
  // an undriven pin wanders, so no level is implied by accident
  always @(posedge clock_i) flt_r <= ~flt_r;
  // module drive wins; a pull-up only holds an otherwise free pin
  assign lvl_o = (oe_i & o_i) | (~oe_i & drv_i & ext_i) | (~oe_i & ~drv_i & (pu_i | flt_r));
endmodule // gpb_board

// *** verif/gpb_bank_assertions.sv ***
// concurrent checks on the port bank
`timescale 1ns/10ps
module gpb_chk
(
  // bus and interrupt
  input wire clock_i,
  input wire rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire [7:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire irq_o,
  // fixed pins
  input wire [7:0] port1_pins_oe_o,
  input wire [7:0] port1_pullup_o,
  input wire [7:0] port3_pins_o,
  input wire [7:0] port3_pins_oe_o,
  input wire [7:0] port3_pullup_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // first access edge of a transfer
  wire acc = psel_i && penable_i && !pready_o;
  wire bad = paddr_i[1:0] != 2'b00 || paddr_i[7:5] > 3'h4;
  property p_ans; acc |=> pready_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err; acc && bad |=> pslverr_o; endproperty
  a_err: assert property (p_err) else $error("no slave error");
  property p_ok; acc && !bad |=> !pslverr_o; endproperty
  a_ok: assert property (p_ok) else $error("false slave error");
  property p_hi; pready_o |-> prdata_o[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits");
  property p_idle; !psel_i ##1 !psel_i |-> !pready_o; endproperty
  a_idle: assert property (p_idle) else $error("stray ready");
  property p_p1; !$past(rst_i) |-> port1_pins_oe_o[5] && !port1_pullup_o[5]; endproperty
  a_p1: assert property (p_p1) else $error("port1 bit5 not output");
  property p_p3; {port3_pins_o[5], port3_pins_oe_o[5], port3_pullup_o[5]} == 3'h0; endproperty
  a_p3: assert property (p_p3) else $error("port3 bit5 active");
  c_err: cover property (pslverr_o);
  c_irq: cover property ($rose(irq_o));
  c_xfer: cover property (acc ##1 pready_o);
endmodule // gpb_chk
bind gpb_bank gpb_chk u_gpb_chk (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .irq_o(irq_o), .port1_pins_oe_o(port1_pins_oe_o),
  .port1_pullup_o(port1_pullup_o), .port3_pins_o(port3_pins_o),
  .port3_pins_oe_o(port3_pins_oe_o), .port3_pullup_o(port3_pullup_o));

// *** verif/gpb_bank_tb.sv ***
// self-checking bench of the port bank
`timescale 1ns/10ps
`include "gpb_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module gpb_bank_tb;
  logic clock_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [7:0] paddr_i = 0, dir, od, out, pup, rd, m, p1, oe_e, o_e;
  logic [31:0] pwdata_i = 0;
  logic [7:0] ext [0:4] = '{default: 8'h00};
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o;
  wire [7:0] pi [0:4], po [0:4], oe [0:4], pu [0:4];
  int num_errors = 0, total_checks = 0, seed = 75952, cyc = 0;
  gpb_bank u_gpb_bank (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .port0_pins_i(pi[0]), .port0_pins_o(po[0]), .port0_pins_oe_o(oe[0]), .port0_pullup_o(pu[0]),
    .port1_pins_i(pi[1]), .port1_pins_o(po[1]), .port1_pins_oe_o(oe[1]), .port1_pullup_o(pu[1]),
    .port2_pins_i(pi[2]), .port2_pins_o(po[2]), .port2_pins_oe_o(oe[2]), .port2_pullup_o(pu[2]),
    .port3_pins_i(pi[3]), .port3_pins_o(po[3]), .port3_pins_oe_o(oe[3]), .port3_pullup_o(pu[3]),
    .port4_pins_i(pi[4]), .port4_pins_o(po[4]), .port4_pins_oe_o(oe[4]), .port4_pullup_o(pu[4]));
  // one board model per port; the board always drives free pins here
  for (genvar g = 0; g < 5; g++)
  begin : g_pad
    gpb_board u_gpb_board (.clock_i(clock_i), .oe_i(oe[g]), .o_i(po[g]), .pu_i(pu[g]),
      .drv_i(8'hff), .ext_i(ext[g]), .lvl_o(pi[g]));
  end
  // 100 mhz clock
  initial forever #5 clock_i = ~clock_i;
  function automatic logic [7:0] adr(int p, logic [2:0] r);
    return {p[2:0], r, 2'b00};
  endfunction
  function automatic logic [7:0] imp(int p);
    return p == 3 ? `GPB_P3_IMPL_MASK : `GPB_ALL_MASK;
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer; an idle edge follows so the next setup never overlaps
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge clock_i) penable_i <= 1;
    // wait for the answer; a hang ends only at the cycle ceiling
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o[7:0];
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clock_i);
  endtask
  // cycle ceiling against a hung handshake
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    for (int p = 0; p < 5; p++)
    begin
      apb(0, adr(p, `GPB_REG_DIR), 0);
      `CHK("dir_rst", (p == 1 ? 8'h20 : 8'h00), rd)
    end
    // random pad setups on every port, port3 bit5 included
    repeat (4) for (int p = 0; p < 5; p++)
    begin
      {dir, od, out, pup} = $random(seed);
      m = imp(p);
      p1 = p == 1 ? 8'h20 : 8'h00;
      ext[p] <= $random(seed);
      apb(1, adr(p, `GPB_REG_OUT), out);
      apb(1, adr(p, `GPB_REG_DIR), dir);
      apb(1, adr(p, `GPB_REG_OD), od);
      apb(1, adr(p, `GPB_REG_PU), pup);
      oe_e = (dir | p1) & (~(od & ~p1) | ~out) & m;
      o_e = out & ~(od & ~p1) & m;
      `CHK("oe", oe_e, oe[p])
      `CHK("pad", o_e, po[p])
      `CHK("pullup", pup & m & ~p1, pu[p])
      apb(0, adr(p, `GPB_REG_DIR), 0);
      `CHK("dir_rd", (dir | p1) & m, rd)
      apb(0, adr(p, `GPB_REG_PIN), 0);
      `CHK("pin", ((oe_e & o_e) | (~oe_e & ext[p])) & m, rd)
    end
    // a pin change latches status; only ports 0, 1 and 4 may interrupt
    for (int p = 0; p < 5; p++)
    begin
      apb(1, adr(p, `GPB_REG_DIR), 0);
      repeat (5) @(posedge clock_i);
      apb(1, adr(p, `GPB_REG_ICLR), 8'hff);
      apb(1, adr(p, `GPB_REG_IEN), 8'h08);
      ext[p] <= ext[p] ^ 8'h09;
      repeat (6) @(posedge clock_i);
      `CHK("irq", `GPB_IRQ_PORTS >> p & 1'b1, irq_o)
      apb(0, adr(p, `GPB_REG_ISTAT), 0);
      `CHK("istat", ((`GPB_IRQ_PORTS >> p & 1'b1) ? 8'h09 : 8'h00), rd)
      apb(1, adr(p, `GPB_REG_IEN), 0);
      repeat (2) @(posedge clock_i);
      `CHK("irq_mask", 1'b0, irq_o)
      apb(1, adr(p, `GPB_REG_ICLR), 8'hff);
      apb(0, adr(p, `GPB_REG_ISTAT), 0);
      `CHK("iclr", 8'h00, rd)
    end
    // unmapped port and misaligned address
    apb(0, 8'ha4, 0);
    `CHK("slverr", 1'b1, err)
    apb(1, 8'h01, 8'hff);
    `CHK("slverr", 1'b1, err)
    give_verdict();
  end
endmodule // gpb_bank_tb
